// [supply_io_pkg.sv]
// supply_io_pkg: constants, types and register map of the supervisor i/o logic
// assumes one 20 MHz core clock and a classic wishbone master on the register side
package supply_io_pkg;

   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int CLK_HZ         = 20_000_000;
   localparam int FILTER_MAX_US  = 100;
   localparam int FILTER_MAX_CYC = FILTER_MAX_US * (CLK_HZ / 1_000_000);
   localparam int PULSE_MAX_US   = 100;
   localparam int PULSE_MAX_CYC  = PULSE_MAX_US * (CLK_HZ / 1_000_000);
   localparam int CLK100K_HZ     = 100_000;
   localparam int CLK100K_HALF   = CLK_HZ / (2 * CLK100K_HZ);

   // ************************************************************
   // sizes
   // ************************************************************
   localparam int AUX_N   = 5;
   localparam int ADC_N   = 12;
   localparam int ADC_W   = 12;
   localparam int PDO_N   = 10;
   localparam int PUMP_N  = 6;
   localparam int AVG_N   = 16;
   localparam int TMO_W   = 11;

   // ************************************************************
   // register byte addresses and field positions
   // ************************************************************
   localparam logic [7:0] CTRL_ADDR     = 8'h00;
   localparam logic [7:0] MASK_ADDR     = 8'h04;
   localparam logic [7:0] AUX_ADDR      = 8'h08;
   localparam logic [7:0] FILT_ADDR     = 8'h0c;
   localparam logic [7:0] RANGE_ADDR    = 8'h10;
   localparam logic [7:0] PDO_BUS_ADDR  = 8'h14;
   localparam logic [7:0] STATUS_ADDR   = 8'h18;
   localparam logic [7:0] PDO_CFG_BASE  = 8'h40;
   localparam logic [7:0] LIMIT_BASE    = 8'h80;
   localparam logic [7:0] RESULT_BASE   = 8'hc0;
   localparam int         LIMIT_MIN_BIT = 12;
   localparam int         PULSE_LSB     = 16;

   // ************************************************************
   // driver output styles and data sources
   // ************************************************************
   localparam logic [2:0] STY_WEAK_PD  = 3'h0;
   localparam logic [2:0] STY_OD       = 3'h1;
   localparam logic [2:0] STY_OD_W_VDD = 3'h2;
   localparam logic [2:0] STY_PP_VDD   = 3'h3;
   localparam logic [2:0] STY_OD_W_VP  = 3'h4;
   localparam logic [2:0] STY_PP_VP    = 3'h5;
   localparam logic [2:0] STY_STRONG_PD = 3'h6;
   localparam logic [2:0] STY_PUMP     = 3'h7;
   localparam logic [1:0] SRC_ENGINE   = 2'h0;
   localparam logic [1:0] SRC_BUS      = 2'h1;
   localparam logic [1:0] SRC_CLK      = 2'h2;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [2:0] {SC_IDLE, SC_SEL, SC_CONV, SC_ADV, SC_FINISH} scan_e;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_s;

endpackage

// [supply_monitor_io_logic.sv]
// supply_monitor_io_logic: aux inputs, converter scan, limits and driver outputs
// assumes a wishbone master, a converter that pulses done with data, synchronous pins
`timescale 1ns/1ns
module supply_monitor_io_logic (
   // clock and reset
   input  wire logic                      core_clk_i,
   input  wire logic                      nrst_i,
   // register bus
   input  wire supply_io_pkg::wb_req_s    wb_i,
   output logic                           wb_ack_o,
   output logic [31:0]                    wb_dat_o,
   // auxiliary inputs and secondary detectors
   input  wire logic [4:0]                aux_pin_i,
   input  wire logic [4:0]                sec_det_i,
   output logic [4:0]                     aux_digital_o,
   output logic [4:0]                     aux_pulldown_o,
   output logic [4:0]                     aux_level_o,
   output logic [9:0]                     sfd_range_o,
   // converter
   output logic                           adc_start_o,
   output logic [3:0]                     adc_chan_o,
   input  wire logic                      adc_done_i,
   input  wire logic [11:0]               adc_data_i,
   // sequence engine
   input  wire logic                      seq_scan_en_i,
   input  wire logic [9:0]                seq_pdo_i,
   output logic                           warn_o,
   // driver outputs
   input  wire logic                      cfg_loaded_i,
   output logic [9:0]                     pdo_data_o,
   output logic [29:0]                    pdo_style_o
);
   import supply_io_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   // every register of the block in one struct
   typedef struct packed {
      logic                          ack;
      logic [31:0]                   rdat;
      logic                          scan_en;
      logic                          avg_en;
      logic [ADC_N-1:0]              mask;
      logic [AUX_N-1:0]              dig;
      logic [AUX_N-1:0]              edge_md;
      logic [AUX_N-1:0]              pd;
      logic [TMO_W-1:0]              tmo;
      logic [TMO_W-1:0]              pw;
      logic [9:0]                    range;
      logic [PDO_N-1:0]              pdo_bus;
      logic [PDO_N-1:0][4:0]         pdo_cfg;
      logic [ADC_N-1:0][12:0]        limit;
      logic [ADC_N-1:0][ADC_W-1:0]   result;
      logic [ADC_N-1:0][ADC_W-1:0]   scratch;
      logic [ADC_N-1:0]              adc_warn;
      logic [AUX_N-1:0]              sec_warn;
      scan_e                         st;
      logic [3:0]                    ch;
      logic [3:0]                    ncnt;
      logic [15:0]                   acc;
      logic                          adc_start;
      logic [3:0]                    adc_chan;
      logic [AUX_N-1:0]              flt;
      logic [AUX_N-1:0][TMO_W-1:0]   fcnt;
      logic [AUX_N-1:0][TMO_W-1:0]   pcnt;
      logic [AUX_N-1:0]              dig_out;
      logic                          warn;
      logic                          loaded;
      logic [7:0]                    div;
      logic                          clk100k;
      logic [PDO_N-1:0]              pdo_data;
      logic [PDO_N-1:0][2:0]         pdo_style;
   } io_state_s;

   // registered copy and its next value
   io_state_s s_r;
   io_state_s s_nxt;
   // combinational helpers of the next-state process
   logic [31:0] rd_w;
   logic [31:0] wr_w;
   logic [3:0]  idx;
   logic        bus_go;
   logic        scan_on;
   logic        last_conv;
   logic [1:0]  src;
   logic [2:0]  sty;

   // ************************************************************
   // helpers
   // ************************************************************
   // byte-lane merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [3:0]  sel);
      logic [31:0] m;
      m = old_w;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            m[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return m;
   endfunction

   // limit compare: bit 12 picks minimum, else maximum
   function automatic logic violates(input logic [ADC_W-1:0] res,
                                     input logic [12:0]      lim);
      if (lim[LIMIT_MIN_BIT]) begin
         return res < lim[ADC_W-1:0];
      end
      return res > lim[ADC_W-1:0];
   endfunction

   // clamp a timeout to its longest setting
   function automatic logic [TMO_W-1:0] clamp(input logic [TMO_W-1:0] v,
                                              input int               lim);
      if (int'(v) > lim) begin
         return TMO_W'(lim);
      end
      return v;
   endfunction

   // ************************************************************
   // next-state logic
   // ************************************************************
   always_comb begin
      s_nxt     = s_r;
      s_nxt.ack = 1'b0;
      s_nxt.adc_start = 1'b0;
      idx       = wb_i.adr[5:2];
      bus_go    = wb_i.cyc && wb_i.stb && !s_r.ack;
      scan_on   = s_r.scan_en | seq_scan_en_i;
      last_conv = s_r.avg_en ? (s_r.ncnt == 4'(AVG_N - 1)) : 1'b1;
      src       = SRC_ENGINE;
      sty       = STY_WEAK_PD;

      // read mux, unmapped reads as zero
      rd_w = 32'h0;
      case (wb_i.adr)
         CTRL_ADDR:    rd_w = {30'h0, s_r.avg_en, s_r.scan_en};
         MASK_ADDR:    rd_w = {20'h0, s_r.mask};
         AUX_ADDR:     rd_w = {17'h0, s_r.pd, s_r.edge_md, s_r.dig};
         FILT_ADDR:    rd_w = {5'h0, s_r.pw, 5'h0, s_r.tmo};
         RANGE_ADDR:   rd_w = {22'h0, s_r.range};
         PDO_BUS_ADDR: rd_w = {22'h0, s_r.pdo_bus};
         STATUS_ADDR:  rd_w = {9'h0, (s_r.st != SC_IDLE), s_r.dig_out,
                               s_r.sec_warn, s_r.adc_warn};
         default: begin
            if (wb_i.adr[7:6] == PDO_CFG_BASE[7:6] && idx < 4'(PDO_N)) begin
               rd_w = {27'h0, s_r.pdo_cfg[idx]};
            end else if (wb_i.adr[7:6] == LIMIT_BASE[7:6] && idx < 4'(ADC_N)) begin
               rd_w = {19'h0, s_r.limit[idx]};
            end else if (wb_i.adr[7:6] == RESULT_BASE[7:6] && idx < 4'(ADC_N)) begin
               rd_w = {20'h0, s_r.result[idx]};
            end
         end
      endcase
      wr_w = merge(rd_w, wb_i.dat, wb_i.sel);

      // bus slave: ack one cycle after the request, writes in the same step
      if (bus_go) begin
         s_nxt.ack  = 1'b1;
         s_nxt.rdat = rd_w;
         if (wb_i.we) begin
            case (wb_i.adr)
               CTRL_ADDR: begin
                  s_nxt.scan_en = wr_w[0];
                  s_nxt.avg_en  = wr_w[1];
               end
               MASK_ADDR:    s_nxt.mask = wr_w[ADC_N-1:0];
               AUX_ADDR: begin
                  s_nxt.dig     = wr_w[4:0];
                  s_nxt.edge_md = wr_w[9:5];
                  s_nxt.pd      = wr_w[14:10];
               end
               FILT_ADDR: begin
                  s_nxt.tmo = clamp(wr_w[TMO_W-1:0], FILTER_MAX_CYC);
                  s_nxt.pw  = clamp(wr_w[PULSE_LSB +: TMO_W], PULSE_MAX_CYC);
               end
               RANGE_ADDR:   s_nxt.range   = wr_w[9:0];
               PDO_BUS_ADDR: s_nxt.pdo_bus = wr_w[PDO_N-1:0];
               default: begin
                  if (wb_i.adr[7:6] == PDO_CFG_BASE[7:6] && idx < 4'(PDO_N)) begin
                     s_nxt.pdo_cfg[idx] = wr_w[4:0];
                  end else if (wb_i.adr[7:6] == LIMIT_BASE[7:6] && idx < 4'(ADC_N)) begin
                     s_nxt.limit[idx] = wr_w[12:0];
                  end
               end
            endcase
         end
      end

      // glitch filter, then level or edge processing per aux input
      for (int i = 0; i < AUX_N; i++) begin
         // pulse counter runs down on its own
         if (s_r.pcnt[i] != '0) begin
            s_nxt.pcnt[i] = TMO_W'(s_r.pcnt[i] - 1'b1);
         end
         if (!s_r.dig[i]) begin
            s_nxt.flt[i]  = 1'b0;
            s_nxt.fcnt[i] = '0;
            s_nxt.pcnt[i] = '0;
         end else if (aux_pin_i[i] == s_r.flt[i]) begin
            s_nxt.fcnt[i] = '0;
         end else if (s_r.fcnt[i] >= s_r.tmo) begin
            s_nxt.flt[i]  = aux_pin_i[i];
            s_nxt.fcnt[i] = '0;
            if (s_r.edge_md[i]) begin
               s_nxt.pcnt[i] = s_r.pw;
            end
         end else begin
            s_nxt.fcnt[i] = TMO_W'(s_r.fcnt[i] + 1'b1);
         end
         // level mode follows the filter, edge mode shows the pulse
         s_nxt.dig_out[i] = s_r.dig[i] &
                            (s_r.edge_md[i] ? (s_nxt.pcnt[i] != '0) : s_nxt.flt[i]);
      end

      // secondary detectors only count in digital mode
      s_nxt.sec_warn = sec_det_i & s_r.dig;

      // round-robin scan controller
      case (s_r.st)
         SC_IDLE: begin
            s_nxt.ch   = 4'h0;
            s_nxt.ncnt = 4'h0;
            s_nxt.acc  = 16'h0;
            if (scan_on) begin
               s_nxt.st = SC_SEL;
            end
         end
         SC_SEL: begin
            if (!scan_on) begin
               s_nxt.st = SC_IDLE;
            end else if (s_r.mask[s_r.ch]) begin
               s_nxt.adc_chan  = s_r.ch;
               s_nxt.adc_start = 1'b1;
               s_nxt.st        = SC_CONV;
            end else begin
               s_nxt.st = SC_ADV;
            end
         end
         SC_CONV: begin
            if (!scan_on) begin
               s_nxt.st = SC_IDLE;
            end else if (adc_done_i) begin
               // sum conversions; a single conversion is the sum itself
               s_nxt.acc = 16'(s_r.acc + {4'h0, adc_data_i});
               if (last_conv) begin
                  s_nxt.scratch[s_r.ch] = s_r.avg_en ? s_nxt.acc[15:4]
                                                     : s_nxt.acc[ADC_W-1:0];
                  s_nxt.ncnt = 4'h0;
                  s_nxt.acc  = 16'h0;
                  s_nxt.st   = SC_ADV;
               end else begin
                  s_nxt.ncnt      = 4'(s_r.ncnt + 1'b1);
                  s_nxt.adc_start = 1'b1;
               end
            end
         end
         SC_ADV: begin
            if (s_r.ch == 4'(ADC_N - 1)) begin
               s_nxt.st = SC_FINISH;
            end else begin
               s_nxt.ch = 4'(s_r.ch + 1'b1);
               s_nxt.st = SC_SEL;
            end
         end
         SC_FINISH: begin
            // publish results and compare limits together
            for (int c = 0; c < ADC_N; c++) begin
               if (s_r.mask[c]) begin
                  s_nxt.result[c]   = s_r.scratch[c];
                  s_nxt.adc_warn[c] = violates(s_r.scratch[c], s_r.limit[c]);
               end
            end
            s_nxt.ch = 4'h0;
            s_nxt.st = scan_on ? SC_SEL : SC_IDLE;
         end
         default: s_nxt.st = SC_IDLE;
      endcase

      // combined warning towards the engine
      s_nxt.warn = (|s_nxt.adc_warn) | (|s_nxt.sec_warn);

      // internal 100 kHz clock
      if (s_r.div == 8'(CLK100K_HALF - 1)) begin
         s_nxt.div     = 8'h0;
         s_nxt.clk100k = ~s_r.clk100k;
      end else begin
         s_nxt.div = 8'(s_r.div + 1'b1);
      end

      // driver outputs
      // configuration loaded is sticky once seen
      s_nxt.loaded = s_r.loaded | cfg_loaded_i;
      for (int p = 0; p < PDO_N; p++) begin
         src = s_r.pdo_cfg[p][4:3];
         sty = s_r.pdo_cfg[p][2:0];
         // no charge pump past output six: open drain instead
         if (sty == STY_PUMP && p >= PUMP_N) begin
            sty = STY_OD;
         end
         case (src)
            SRC_BUS: s_nxt.pdo_data[p] = s_r.pdo_bus[p];
            SRC_CLK: s_nxt.pdo_data[p] = s_nxt.clk100k;
            default: s_nxt.pdo_data[p] = seq_pdo_i[p];
         endcase
         s_nxt.pdo_style[p] = sty;
         if (!s_nxt.loaded) begin
            s_nxt.pdo_data[p]  = 1'b0;
            s_nxt.pdo_style[p] = STY_WEAK_PD;
         end
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign wb_ack_o       = s_r.ack;
   assign wb_dat_o       = s_r.rdat;
   assign aux_digital_o  = s_r.dig;
   assign aux_pulldown_o = s_r.dig & s_r.pd;
   assign aux_level_o    = s_r.dig_out;
   assign sfd_range_o    = s_r.range;
   assign adc_start_o    = s_r.adc_start;
   assign adc_chan_o     = s_r.adc_chan;
   assign warn_o         = s_r.warn;
   assign pdo_data_o     = s_r.pdo_data;
   assign pdo_style_o    = s_r.pdo_style;

endmodule

// [supply_adc_model.sv]
// supply_adc_model: converter that answers each start after a random delay
// assumes one start at a time; per-channel codes come from a packed table
`timescale 1ns/1ns
module supply_adc_model (
   // clock
   input  wire logic          core_clk_i,
   // converter side
   input  wire logic          adc_start_i,
   input  wire logic [3:0]    adc_chan_i,
   input  wire logic [143:0]  val_i,
   output logic               adc_done_o,
   output logic [11:0]        adc_data_o
);
   logic [3:0] last_ch;
   int         run;

   // one conversion: wait, pulse done with the code, then spoil the data
   initial begin
      adc_done_o = 1'b0;
      adc_data_o = 12'h0;
      last_ch = 4'hf;
      run = 0;
      forever begin
         @(posedge core_clk_i);
         if (adc_start_i === 1'b1) begin
            // repeats on one channel add 0..15 so a short average shows
            run = (adc_chan_i == last_ch) ? run + 1 : 0;
            last_ch = adc_chan_i;
            repeat (1 + $urandom_range(3)) @(posedge core_clk_i);
            adc_done_o <= 1'b1;
            adc_data_o <= val_i[int'(adc_chan_i) * 12 +: 12] + 12'(run % 16);
            @(posedge core_clk_i);
            adc_done_o <= 1'b0;
            adc_data_o <= ~adc_data_o; // data not valid outside done
         end
      end
   end
endmodule

// [supply_monitor_io_logic_checker.sv]
// supply_monitor_io_logic_checker: port-level assertions for the io logic
// assumes it is bound into every instance of supply_monitor_io_logic
`timescale 1ns/1ns
module supply_monitor_io_logic_checker (
   // clock and reset
   input  wire logic                   core_clk_i,
   input  wire logic                   nrst_i,
   // register bus
   input  wire supply_io_pkg::wb_req_s wb_i,
   input  wire logic                   wb_ack_o,
   // converter
   input  wire logic                   adc_start_o,
   input  wire logic [3:0]             adc_chan_o,
   input  wire logic                   adc_done_i,
   // aux and warnings
   input  wire logic [4:0]             sec_det_i,
   input  wire logic [4:0]             aux_digital_o,
   input  wire logic [4:0]             aux_pulldown_o,
   input  wire logic                   warn_o,
   // driver outputs
   input  wire logic                   cfg_loaded_i,
   input  wire logic [9:0]             pdo_data_o,
   input  wire logic [29:0]            pdo_style_o
);
   import supply_io_pkg::*;
   logic cfg_seen_r;

   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);

   // configuration seen once, sticky
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_seen_r <= 1'b0;
      end else if (cfg_loaded_i) begin
         cfg_seen_r <= 1'b1;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   bus_answer_a: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   start_pulse_a: assert property (adc_start_o |=> !adc_start_o)
      else $error("conversion start longer than one cycle");
   chan_range_a: assert property (adc_start_o |-> adc_chan_o < 4'hc)
      else $error("conversion channel out of range");
   chan_hold_a: assert property (adc_done_i |-> $stable(adc_chan_o))
      else $error("channel changed during conversion");
   sec_warn_a: assert property (|(sec_det_i & aux_digital_o) |-> ##[1:3] warn_o)
      else $error("secondary warning not on combined warning");
   pulldown_mode_a: assert property ((aux_pulldown_o & ~aux_digital_o) == 5'h0)
      else $error("pull-down enabled on an analog input");
   pdo_default_a: assert property (!cfg_seen_r && !cfg_loaded_i |=>
      pdo_data_o == 10'h0 && pdo_style_o == 30'h0)
      else $error("driver output not at default before configuration");
   pump_limit_a: assert property (pdo_style_o[20:18] != 3'h7 && pdo_style_o[23:21] != 3'h7
      && pdo_style_o[26:24] != 3'h7 && pdo_style_o[29:27] != 3'h7)
      else $error("charge pump style on outputs seven to ten");
endmodule

bind supply_monitor_io_logic supply_monitor_io_logic_checker chk_u (
   .core_clk_i(core_clk_i), .nrst_i(nrst_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o),
   .adc_start_o(adc_start_o), .adc_chan_o(adc_chan_o), .adc_done_i(adc_done_i),
   .sec_det_i(sec_det_i), .aux_digital_o(aux_digital_o), .aux_pulldown_o(aux_pulldown_o),
   .warn_o(warn_o), .cfg_loaded_i(cfg_loaded_i), .pdo_data_o(pdo_data_o),
   .pdo_style_o(pdo_style_o)
);

// [supply_monitor_io_logic_tb_top.sv]
// supply_monitor_io_logic_tb_top: self-checking bench for the io logic
// assumes the converter model and the bound checker are compiled alongside
`timescale 1ns/1ns
module supply_monitor_io_logic_tb_top;
   import supply_io_pkg::*;
   // ************************************************************
   // signals and bookkeeping
   // ************************************************************
   logic          clk = 1'b0;
   logic          nrst = 1'b0;
   wb_req_s       wb = '0;
   logic          ack, st, done, sen = 1'b0, warn, cfg = 1'b0;
   logic [31:0]   rdat;
   logic [4:0]    pin = 5'h0, sec = 5'h0, dig, pd, lvl;
   logic [9:0]    rng, spdo = 10'h0, pdat;
   logic [3:0]    ch;
   logic [11:0]   dat;
   logic [29:0]   psty;
   logic [143:0]  vals;
   logic [31:0]   exp_q[$], msk_q[$];
   int            errors = 0, cmp_count = 0, tot = 0, cnt[12] = '{default: 0}, b, hi;

   supply_monitor_io_logic dut_u (.core_clk_i(clk), .nrst_i(nrst), .wb_i(wb), .wb_ack_o(ack),
      .wb_dat_o(rdat), .aux_pin_i(pin), .sec_det_i(sec), .aux_digital_o(dig),
      .aux_pulldown_o(pd), .aux_level_o(lvl), .sfd_range_o(rng), .adc_start_o(st),
      .adc_chan_o(ch), .adc_done_i(done), .adc_data_i(dat), .seq_scan_en_i(sen),
      .seq_pdo_i(spdo), .warn_o(warn), .cfg_loaded_i(cfg), .pdo_data_o(pdat),
      .pdo_style_o(psty));
   supply_adc_model adc_u (.core_clk_i(clk), .adc_start_i(st), .adc_chan_i(ch),
      .val_i(vals), .adc_done_o(done), .adc_data_o(dat));

   // 20 MHz clock
   always #25 clk = ~clk;

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // one classic cycle, held until ack is sampled high
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      wb <= '{1'b1, 1'b1, we, a, 4'hf, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      wb <= '0;
      @(posedge clk);
      if (n >= 50) begin
         chk(32'h0, 32'h1);
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic wait_cnt(input int c, input int n);
      for (int i = 0; i < 5000 && cnt[c] < n; i++) @(posedge clk);
      if (cnt[c] < n) begin
         chk(32'h0, 32'h1);
         report_and_stop();
      end
   endtask
   task automatic count_hi(input int s, input int n, output int h);
      h = 0;
      repeat (n) begin
         @(posedge clk);
         h += (s < 5) ? int'(lvl[s]) : int'(pdat[2]);
      end
   endtask

   // read data against the oldest note; conversion starts per channel
   always @(posedge clk) begin
      if (ack === 1'b1 && wb.we === 1'b0) begin
         chk(rdat & msk_q[0], exp_q[0] & msk_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
      if (st === 1'b1 && ch < 4'hc) begin
         cnt[ch]++;
         tot++;
      end
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      void'($urandom(61)); // seed once for the whole run
      for (int c = 0; c < 12; c++) vals[c * 12 +: 12] = 12'($urandom_range(12'he00, 12'h100));
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(CTRL_ADDR, 32'h0, 32'hffff_ffff);
      wr(8'h30, 32'hffff_ffff);
      rd(8'h30, 32'h0, 32'hffff_ffff);
      // driver outputs: default, bus, pump limit, engine, clock
      wr(PDO_CFG_BASE, 32'h0b);
      wr(PDO_BUS_ADDR, 32'h3ff);
      repeat (3) @(posedge clk);
      chk(32'(pdat), 32'h0);
      chk(32'(psty), 32'h0);
      cfg <= 1'b1;
      repeat (3) @(posedge clk);
      chk(32'(pdat[0]), 32'h1);
      chk(32'(psty[2:0]), 32'h3);
      spdo <= 10'($urandom);
      wr(PDO_CFG_BASE, 32'h07);
      wr(PDO_CFG_BASE + 8'd24, 32'h07);
      repeat (3) @(posedge clk);
      chk(32'(psty[2:0]), 32'h7);
      chk(32'(psty[20:18]), 32'h1);
      chk(32'({pdat[6], pdat[0]}), 32'({spdo[6], spdo[0]}));
      wr(PDO_CFG_BASE + 8'd8, 32'h13);
      count_hi(5, 4 * CLK100K_HALF, hi);
      chk(32'(hi), 32'(2 * CLK100K_HALF));
      // aux inputs: mode, pull-down, range, filter, level, edge
      wr(FILT_ADDR, 32'h000a_0005);
      wr(AUX_ADDR, 32'h443);
      wr(RANGE_ADDR, 32'h2a5);
      repeat (3) @(posedge clk);
      chk(32'({rng, pd, dig}), 32'({10'h2a5, 5'h01, 5'h03}));
      pin[0] <= 1'b1;
      repeat (4) @(posedge clk);
      pin[0] <= 1'b0;
      count_hi(0, 20, hi);
      chk(32'(hi), 32'h0);
      pin[0] <= 1'b1;
      repeat (4) @(posedge clk);
      chk(32'(lvl[0]), 32'h0);
      repeat (10) @(posedge clk);
      chk(32'(lvl[0]), 32'h1);
      pin[1] <= 1'b1;
      count_hi(1, 40, hi);
      chk(32'(hi), 32'd10);
      // secondary warnings only from digital-mode inputs
      sec <= 5'h01;
      repeat (4) @(posedge clk);
      chk(32'(warn), 32'h1);
      rd(STATUS_ADDR, 32'h0_1000, 32'h1_f000);
      sec <= 5'h10;
      repeat (4) @(posedge clk);
      chk(32'(warn), 32'h0);
      rd(STATUS_ADDR, 32'h0, 32'h1_f000);
      sec <= 5'h00;
      // scan of channels 0 and 11 with both limits violated
      wr(LIMIT_BASE, 32'(vals[11:0]) - 32'h1);
      wr(LIMIT_BASE + 8'd44, 32'h1000 | (32'(vals[143:132]) + 32'h1));
      wr(MASK_ADDR, 32'h801);
      wr(CTRL_ADDR, 32'h1);
      wait_cnt(11, 3);
      repeat (10) @(posedge clk);
      rd(RESULT_BASE, 32'(vals[11:0]), 32'hfff);
      rd(RESULT_BASE + 8'd44, 32'(vals[143:132]), 32'hfff);
      rd(STATUS_ADDR, 32'h801, 32'hfff);
      chk(32'(warn), 32'h1);
      // limits equal to the codes: no warning either way
      wr(LIMIT_BASE, 32'(vals[11:0]));
      wr(LIMIT_BASE + 8'd44, 32'h1000 | 32'(vals[143:132]));
      wait_cnt(11, cnt[11] + 2);
      repeat (10) @(posedge clk);
      rd(STATUS_ADDR, 32'h0, 32'hfff);
      chk(32'(warn), 32'h0);
      wr(CTRL_ADDR, 32'h0);
      chk(32'(cnt[0] - cnt[11] inside {0, 1}), 32'h1);
      chk(32'(tot - cnt[0] - cnt[11]), 32'h0);
      // empty mask converts nothing
      wr(MASK_ADDR, 32'h0);
      wr(CTRL_ADDR, 32'h1);
      b = tot;
      repeat (100) @(posedge clk);
      chk(32'(tot - b), 32'h0);
      // averaging on channel 2, scan started by the engine
      wr(CTRL_ADDR, 32'h2);
      wr(MASK_ADDR, 32'h4);
      sen <= 1'b1;
      wait_cnt(2, cnt[2] + 40);
      repeat (10) @(posedge clk);
      rd(RESULT_BASE + 8'd8, 32'(vals[35:24]) + 32'h7, 32'hfff);
      sen <= 1'b0;
      repeat (5) @(posedge clk);
      report_and_stop();
   end
endmodule
